/* common/fsg_pkg.sv */
/*
  Constants for the flash security gate: register map, field positions,
  command codes, operating modes and reset values.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package fsg_pkg;
  // register byte addresses
  localparam logic [7:0] A_MODE   = 8'h00;
  localparam logic [7:0] A_OPTION = 8'h04;
  localparam logic [7:0] A_GUARD  = 8'h08;
  localparam logic [7:0] A_CMD    = 8'h0C;
  localparam logic [7:0] A_RESULT = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_MASK   = 8'h18;
  // operating modes
  localparam logic [1:0] M_MCU      = 2'h0;
  localparam logic [1:0] M_SERIAL   = 2'h1;
  localparam logic [1:0] M_PARALLEL = 2'h2;
  localparam logic [1:0] M_DEBUG    = 2'h3;
  localparam int MODE_RAMX = 2;
  // commands
  localparam logic [7:0] C_ERASE    = 8'hF0;
  localparam logic [7:0] C_WRITE    = 8'h30;
  localparam logic [7:0] C_READ     = 8'h40;
  localparam logic [7:0] C_RAMLOAD  = 8'h60;
  localparam logic [7:0] C_SECSET   = 8'hFA;
  localparam logic [7:0] C_PAGEPROG = 8'h01;
  localparam logic [7:0] C_DBGSTART = 8'h04;
  localparam logic [7:0] OPT_FREE   = 8'hFF;
  // CMD register fields
  localparam int CMD_SECTOR = 8;
  localparam int CMD_PWOK   = 9;
  localparam int CMD_PTROK  = 10;
  localparam int CMD_GLO    = 11;
  localparam int CMD_GHI    = 13;
  // OPTION register fields
  localparam int OPT_DBG_LO = 8;
  // event / result bit positions
  localparam int EV_GRANT  = 0;
  localparam int EV_REFUSE = 1;
  localparam int EV_LOCK   = 2;
  localparam int RES_BUSY  = 3;
  localparam int EV_W      = 3;
  // reset values
  localparam logic [2:0] GUARD_ERASED = 3'h7;
  localparam logic [7:0] OPT_RST      = 8'hFF;
  localparam logic [1:0] HTRANS_NSEQ  = 2'h2;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_EVAL = 2'h1,
    S_DONE = 2'h3,
    S_LOCK = 2'h2
  } gate_state_e;
endpackage

/* hw/flash_security_gate.sv */
/*
  Flash security gate: decides whether flash commands and debugger
  startup may proceed, holds the three guard bits and the two option
  bytes, and answers on an AHB-Lite register slave.
  Assumes a single 10 MHz clock, synchronous active-low reset, and that
  software copies the option bytes from the vector area into OPTION.
*/
module flash_security_gate
  import fsg_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // gate outcome
  output logic             op_grant,
  output logic             op_refuse,
  output logic             lockout,
  output logic             irq
);
  import fsg_pkg::*;

  gate_state_e state_q, state_d;

  logic [1:0]      mode_q;
  logic            ramx_q;
  logic [7:0]      erase_auth_option_byte;
  logic [7:0]      debug_guard_bypass_byte;
  logic            readout_guard_bit_low;
  logic            readout_guard_bit_high;
  logic            self_program_guard_bit;
  logic [13:0]     cmd_q;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] result_q;
  logic            wr_pend_q;
  logic [7:0]      addr_q;

  // address phase capture
  wire take      = hsel & hready & htrans[1];
  wire wr_phase  = wr_pend_q;
  wire wr_mode   = wr_phase & (addr_q == A_MODE);
  wire wr_opt    = wr_phase & (addr_q == A_OPTION);
  wire wr_cmd    = wr_phase & (addr_q == A_CMD) & (state_q == S_IDLE);
  wire wr_status = wr_phase & (addr_q == A_STATUS);
  wire wr_mask   = wr_phase & (addr_q == A_MASK);

  // guard decode: a programmed (zero) bit means enabled
  wire readout_on = ~readout_guard_bit_low | ~readout_guard_bit_high;
  wire self_on    = ~self_program_guard_bit;
  wire guard_any  = readout_on | self_on;

  wire [7:0] code   = cmd_q[7:0];
  wire       sector = cmd_q[CMD_SECTOR];
  wire       pw_ok  = cmd_q[CMD_PWOK];
  wire       ptr_ok = cmd_q[CMD_PTROK];
  wire       auth   = pw_ok & ptr_ok;
  wire       erase_free = (erase_auth_option_byte == OPT_FREE);
  wire       dbg_free   = (debug_guard_bypass_byte == OPT_FREE);

  // decision, made from the guard bits as they stand at evaluation
  logic d_grant;
  logic d_lock;
  logic d_clear;
  logic d_prog;
  always_comb begin
    d_grant = 1'b0;
    d_lock  = 1'b0;
    d_clear = 1'b0;
    d_prog  = 1'b0;
    case (mode_q)
      M_PARALLEL: begin
        if (code == C_ERASE) begin
          d_grant = 1'b1;
          d_clear = 1'b1;
        end else if (code == C_READ || code == C_WRITE) begin
          d_grant = ~readout_on;
        end
      end
      M_SERIAL: begin
        if (code == C_ERASE) begin
          if (erase_free && sector) begin
            d_lock = 1'b1;
          end else if (erase_free) begin
            d_grant = ptr_ok;
            d_lock  = ~ptr_ok;
          end else begin
            d_grant = auth;
            d_lock  = ~auth;
          end
          d_clear = d_grant & ~sector;
        end else if (code == C_WRITE || code == C_READ || code == C_RAMLOAD) begin
          if (!auth) begin
            d_lock = 1'b1;
          end else begin
            d_grant = ~guard_any;
          end
        end else if (code == C_SECSET) begin
          d_grant = auth;
          d_lock  = ~auth;
          d_prog  = auth;
        end
      end
      M_DEBUG: begin
        if (code == C_DBGSTART) begin
          if (!pw_ok) begin
            d_lock = 1'b1;
          end else if (dbg_free) begin
            d_grant = 1'b1;
          end else if (guard_any) begin
            d_lock = 1'b1;
          end else begin
            d_grant = 1'b1;
          end
        end
      end
      default: begin
        // mcu mode; ram-run code falls under the same page-program gate
        if (code == C_PAGEPROG) begin
          d_grant = ~self_on;
        end
      end
    endcase
  end

  // state machine: lockout is left only through reset
  always_comb begin
    case (state_q)
      S_IDLE:  state_d = wr_cmd ? S_EVAL : S_IDLE;
      S_EVAL:  state_d = d_lock ? S_LOCK : S_DONE;
      S_DONE:  state_d = S_IDLE;
      S_LOCK:  state_d = S_LOCK;
      default: state_d = S_IDLE;
    endcase
  end

  wire       evaluating = (state_q == S_EVAL);
  wire       ev_grant   = evaluating & d_grant & ~d_lock;
  wire       ev_refuse  = evaluating & ~d_grant & ~d_lock;
  wire       ev_lock    = evaluating & d_lock;
  wire [EV_W-1:0] ev_set = {ev_lock, ev_refuse, ev_grant};
  wire [EV_W-1:0] w1c    = wr_status ? hwdata[EV_W-1:0] : '0;
  // a fresh event wins over a simultaneous clear
  wire [EV_W-1:0] status_d = ev_set | (status_q & ~w1c);

  // guard memory: programmed bits go to zero, chip erase restores ones
  wire [2:0] prog_mask = cmd_q[CMD_GHI:CMD_GLO];
  wire [2:0] guard_q   = {self_program_guard_bit, readout_guard_bit_high,
                          readout_guard_bit_low};
  wire [2:0] guard_d   = (evaluating & d_clear & ~d_lock) ? GUARD_ERASED :
                         (evaluating & d_prog) ? (guard_q & ~prog_mask) : guard_q;

  // read mux, registered so the data phase sees it
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr)
      A_MODE:   rd_mux = {29'h0, ramx_q, mode_q};
      A_OPTION: rd_mux = {16'h0, debug_guard_bypass_byte, erase_auth_option_byte};
      A_GUARD:  rd_mux = {29'h0, guard_q};
      A_CMD:    rd_mux = {18'h0, cmd_q};
      A_RESULT: rd_mux = {28'h0, (state_q == S_EVAL), result_q};
      A_STATUS: rd_mux = {29'h0, status_q};
      A_MASK:   rd_mux = {29'h0, mask_q};
      default:  rd_mux = 32'h0;
    endcase
  end

  // bus slave: one address phase, data phase on the next cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (ce) begin
      wr_pend_q <= take & hwrite;
      addr_q    <= take ? haddr : addr_q;
    end
  end

  // read data stands for the data phase only, zero otherwise
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hrdata <= 32'h0;
    end else if (ce) begin
      hrdata <= (take & ~hwrite) ? rd_mux : 32'h0;
    end
  end

  // kept as flops so that every output leaves a register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_q <= M_MCU;
      ramx_q <= 1'b0;
    end else if (ce) begin
      if (wr_mode) begin
        mode_q <= hwdata[1:0];
        ramx_q <= hwdata[MODE_RAMX];
      end
    end
  end

  // option bytes are a software copy; a stale copy weakens the gate
  always_ff @(posedge clk) begin
    if (!resetn) begin
      erase_auth_option_byte  <= OPT_RST;
      debug_guard_bypass_byte <= OPT_RST;
    end else if (ce) begin
      if (wr_opt) begin
        erase_auth_option_byte  <= hwdata[7:0];
        debug_guard_bypass_byte <= hwdata[OPT_DBG_LO+7:OPT_DBG_LO];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mask_q <= '0;
    end else if (ce) begin
      if (wr_mask) begin
        mask_q <= hwdata[EV_W-1:0];
      end
    end
  end

  // gate state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= S_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // a command is taken only while idle, so lockout cannot be overwritten
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_q <= '0;
    end else if (ce) begin
      if (wr_cmd) begin
        cmd_q <= hwdata[CMD_GHI:0];
      end
    end
  end

  // guard bits stand in for dedicated memory; persistence is not modelled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      readout_guard_bit_low  <= GUARD_ERASED[0];
      readout_guard_bit_high <= GUARD_ERASED[1];
      self_program_guard_bit <= GUARD_ERASED[2];
    end else if (ce) begin
      {self_program_guard_bit, readout_guard_bit_high, readout_guard_bit_low} <= guard_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_q <= '0;
    end else if (ce) begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_q <= '0;
    end else if (ce) begin
      if (evaluating) begin
        result_q <= ev_set;
      end
    end
  end

  // outcome pins, all from flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      op_grant <= 1'b0;
    end else if (ce) begin
      op_grant <= ev_grant;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      op_refuse <= 1'b0;
    end else if (ce) begin
      op_refuse <= ev_refuse;
    end
  end

  // taken from the next state so lockout rises with the decision
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lockout <= 1'b0;
    end else if (ce) begin
      lockout <= (state_d == S_LOCK);
    end
  end

  // level interrupt; follows status in the same cycle and mask one cycle late
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status_d & mask_q);
    end
  end
endmodule

/* verification/flash_security_gate_checker.sv */
/* Checker for the gate outcome pins.
   Assumes ce tied high and hready fed from hreadyout. */
module flash_security_gate_checker
  import fsg_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // bus request
  input wire logic       hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  // slave and gate outputs
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       op_grant,
  input wire logic       op_refuse,
  input wire logic       lockout
);
  timeunit 1ns;
  timeprecision 1ns;
  wire cmd_wr = hsel && hreadyout && htrans[1] && hwrite && (haddr == A_CMD);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or error");
  property p_grant_src; op_grant |-> $past(cmd_wr, 3); endproperty
  a_grant_src: assert property (p_grant_src) else $error("stray grant");
  property p_refuse_src; op_refuse |-> $past(cmd_wr, 3); endproperty
  a_refuse_src: assert property (p_refuse_src) else $error("stray refuse");
  property p_lock_src; $rose(lockout) |-> $past(cmd_wr, 3); endproperty
  a_lock_src: assert property (p_lock_src) else $error("stray lockout");
  property p_lock_hold; lockout |=> lockout [*4]; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout dropped");
  property p_lock_mute; lockout |-> !op_grant && !op_refuse; endproperty
  a_lock_mute: assert property (p_lock_mute) else $error("outcome in lockout");
  property p_one; !(op_grant && op_refuse); endproperty
  a_one: assert property (p_one) else $error("grant with refuse");
  property p_pulse; $rose(op_grant) |=> !op_grant; endproperty
  a_pulse: assert property (p_pulse) else $error("grant too long");
  c_grant: cover property (op_grant);
  c_refuse: cover property (op_refuse);
  c_lock: cover property ($rose(lockout));
endmodule

/* verification/host_model.sv */
/* Programming host: AHB-Lite master doing single word transfers.
   Assumes one slave whose hreadyout is its hready. */
module host_model
  import fsg_pkg::*;
(
  // clock and slave answer
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // request
  output logic             hsel,
  output logic      [7:0]  haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  output logic             tmo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata, tmo} = '0;
  end
  // entered just after a rising edge; released address and data lines show the inverse, never stale data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    do begin @(posedge clk); n++; end while (!hready && n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (!hready && n < 64);
    q = hrdata;
    hwdata <= ~d;
    if (n >= 64) tmo <= 1'b1;
  endtask
endmodule

/* verification/flash_security_gate_tb.sv */
/* Bench for the flash security gate: a table of mode, option and command
   cases with expected result and guard bits. Assumes host_model. */
module flash_security_gate_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fsg_pkg::*;
  typedef struct packed {
    logic [2:0]  m;
    logic [15:0] o;
    logic [15:0] c;
    logic [2:0]  r;
    logic [2:0]  g;
  } vec_s;
  logic        clk, resetn, hsel, hwrite, hreadyout, tmo, op_grant, op_refuse, lockout, irq;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic        g_seen, r_seen;
  int          n_errors = 0;
  int          n_checks = 0;
  vec_s        v [21];
  flash_security_gate dut (.clk(clk), .resetn(resetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .op_grant(op_grant),
    .op_refuse(op_refuse), .lockout(lockout), .irq(irq));
  host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .tmo(tmo));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    host.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge tmo) begin
    n_errors++;
    test_done();
  end
  initial begin
    resetn = 1'b0;
    v = '{'{3'h0, 16'hFFFF, 16'h0001, 3'h1, 3'h7},
          '{3'h1, 16'hFFFF, 16'h0640, 3'h1, 3'h7},
          '{3'h1, 16'hFFFF, 16'h1EFA, 3'h1, 3'h4},
          '{3'h1, 16'hFFFF, 16'h0640, 3'h2, 3'h4},
          '{3'h1, 16'hFFFF, 16'h0630, 3'h2, 3'h4},
          '{3'h1, 16'hFFFF, 16'h0660, 3'h2, 3'h4},
          '{3'h2, 16'hFFFF, 16'h0040, 3'h2, 3'h4},
          '{3'h2, 16'hFFFF, 16'h0030, 3'h2, 3'h4},
          '{3'h1, 16'hFFFF, 16'h26FA, 3'h1, 3'h0},
          '{3'h0, 16'hFFFF, 16'h0001, 3'h2, 3'h0},
          '{3'h4, 16'hFFFF, 16'h0001, 3'h2, 3'h0},
          '{3'h3, 16'hFFFF, 16'h0204, 3'h1, 3'h0},
          '{3'h2, 16'h0000, 16'h00F0, 3'h1, 3'h7},
          '{3'h2, 16'hFFFF, 16'h0040, 3'h1, 3'h7},
          '{3'h3, 16'h0000, 16'h0204, 3'h1, 3'h7},
          '{3'h1, 16'hFFFF, 16'h04F0, 3'h1, 3'h7},
          '{3'h1, 16'hFFFF, 16'h05F0, 3'h4, 3'h7},
          '{3'h1, 16'hFF00, 16'h04F0, 3'h4, 3'h7},
          '{3'h1, 16'hFFFF, 16'h0430, 3'h4, 3'h7},
          '{3'h1, 16'hFFFF, 16'h0EFA, 3'h1, 3'h6},
          '{3'h3, 16'h0000, 16'h0204, 3'h4, 3'h6}};
    @(posedge clk);
    do_reset();
    rd(A_OPTION, 32'hFFFF, "option");
    wr(A_GUARD, 32'h0);
    rd(A_GUARD, 32'h7, "guard");
    rd(8'h1C, 32'h0, "unmapped");
    foreach (v[i]) begin
      wr(A_MODE, {29'h0, v[i].m});
      wr(A_OPTION, {16'h0, v[i].o});
      wr(A_CMD, {16'h0, v[i].c});
      // three cycles: decision lands and the gate is idle again; pulses caught here
      g_seen = 1'b0;
      r_seen = 1'b0;
      repeat (3) begin
        @(posedge clk);
        g_seen = g_seen | op_grant;
        r_seen = r_seen | op_refuse;
      end
      chk("grant pin", {31'h0, v[i].r[0]}, {31'h0, g_seen});
      chk("refuse pin", {31'h0, v[i].r[1]}, {31'h0, r_seen});
      rd(A_RESULT, {29'h0, v[i].r}, "result");
      if (v[i].r == 3'h4) begin
        chk("lockout", 32'h1, {31'h0, lockout});
        wr(A_CMD, 32'h0204);
        repeat (3) @(posedge clk);
        rd(A_RESULT, 32'h4, "locked result");
        do_reset();
      end else begin
        rd(A_GUARD, {29'h0, v[i].g}, "guard");
      end
    end
    wr(A_MASK, 32'h2);
    wr(A_CMD, 32'h0001);
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(A_STATUS, 32'h1, "status");
    wr(A_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(A_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    test_done();
  end
endmodule
bind flash_security_gate flash_security_gate_checker gate_chk (.clk(clk), .resetn(resetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .hresp(hresp), .op_grant(op_grant), .op_refuse(op_refuse), .lockout(lockout));
